// *** design/l2ami_top.sv ***
// Purpose: issue processor and coherency traffic onto one or two 64-bit master ports
// Assumes: completions come back tagged with the class id that was issued
// Notes: illegal processor shapes are legalised, not refused
// Function
// - master_port_zero always present, master_port_one optional, both 64-bit data.
// - master_port_one takes requests whose address lies in its filter window.
// - one processor: 29 writes, coherency 15, nc 8, evict 4, direct 2.
// - two processors: 41 writes, coherency 15 plus per-processor nc, evict, direct; the per-class limits here allow 43.
// - one processor: 31 reads, coherency 15, dfill 4, ifill 8, nc 4.
// - two processors: 47 reads, coherency 15 plus per-processor classes.
// - reads plus writes outstanding never exceed 88.
// - write data of different writes never interleaves.
// - coherency traffic passes with any length and size; FIXED bursts become INCR.
// - linefills are WRAP4 64-bit, evictions INCR4 64-bit.
// - instruction non-cacheable reads are WRAP4 64-bit.
// - nc 64-bit reads INCR 1-4 beats, nc 64-bit writes single beat.
// - nc 32-bit reads INCR 1-8 beats.
// - nc 32-bit writes 1-2 beats, 8 and 16-bit single beat.
// - exclusive accesses single-beat INCR of any size.
// - swaps locked single-beat INCR, 8 or 32 bits only.
// - WRAP only on 64-bit four-beat reads, bursts 32/64-bit, no FIXED.
// - port zero read user: bit6 speculative hint, bit5 zero, bit0 shareable.
// - user bits 8:7 carry source, 11 never driven.
// - user bits 4:1 carry the inner memory attribute.
// - write-through regions encode attribute as 0110.
`include "l2ami_defs.svh"
module l2ami_top #(
  parameter int NUM_CPU = 2,
  parameter bit HAS_PORT1 = 1'b1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // request stream
  input wire logic req_valid_i,
  input wire l2ami_pkg::l2ami_req_t req_i,
  output logic req_ready_o,
  // write data stream
  input wire logic wdat_valid_i,
  input wire l2ami_pkg::l2ami_wdat_t wdat_i,
  output logic wdat_ready_o,
  // master_port_one address filter, inclusive bounds
  input wire logic [31:0] port1_base_i,
  input wire logic [31:0] port1_limit_i,
  // address channels of both ports
  output logic [1:0] addr_valid_o,
  output l2ami_pkg::l2ami_ach_t [1:0] addr_o,
  input wire logic [1:0] addr_ready_i,
  // write data channels
  output logic [1:0] w_valid_o,
  output l2ami_pkg::l2ami_wdat_t w_o,
  input wire logic [1:0] w_ready_i,
  // completions, one per port group
  input wire logic rd_done_i,
  input wire l2ami_pkg::l2ami_cls_t rd_done_cls_i,
  input wire logic wr_done_i,
  input wire l2ami_pkg::l2ami_cls_t wr_done_cls_i,
  // status
  output logic [6:0] outstanding_o,
  output logic wr_busy_o
);
  import l2ami_pkg::*;

  l2ami_st_t st_reg;
  l2ami_st_t st_next;
  l2ami_ach_t form;
  logic tgt;
  logic is_wr;
  logic take;
  logic wtake;
  logic lim_ok;
  logic [6:0] rd_sum;
  logic [6:0] wr_sum;

  // ************************************************
  // class limits and source codes
  // ************************************************
  // per-processor limits fall to zero on processor one when absent
  function automatic logic [4:0] lim(input l2ami_cls_t c);
    logic two;
    two = (NUM_CPU > 1);
    unique case (c)
      CL_CP_RD, CL_CP_WR: lim = `L2AMI_LIM_CP;
      CL_P0_DFILL: lim = `L2AMI_LIM_DFILL;
      CL_P0_IFILL: lim = `L2AMI_LIM_IFILL;
      CL_P0_NCRD: lim = `L2AMI_LIM_NCRD;
      CL_P0_NCWR: lim = `L2AMI_LIM_NCWR;
      CL_P0_EVICT: lim = `L2AMI_LIM_EVICT;
      CL_P0_DDI: lim = `L2AMI_LIM_DDI;
      CL_P1_DFILL: lim = two ? `L2AMI_LIM_DFILL : 5'h00;
      CL_P1_IFILL: lim = two ? `L2AMI_LIM_IFILL : 5'h00;
      CL_P1_NCRD: lim = two ? `L2AMI_LIM_NCRD : 5'h00;
      CL_P1_NCWR: lim = two ? `L2AMI_LIM_NCWR : 5'h00;
      CL_P1_EVICT: lim = two ? `L2AMI_LIM_EVICT : 5'h00;
      CL_P1_DDI: lim = two ? `L2AMI_LIM_DDI : 5'h00;
      default: lim = 5'h00;
    endcase
  endfunction

  function automatic logic [1:0] src(input l2ami_cls_t c);
    unique case (c)
      CL_CP_RD, CL_CP_WR: src = `L2AMI_SRC_CP;
      CL_P1_DFILL, CL_P1_IFILL, CL_P1_NCRD, CL_P1_NCWR, CL_P1_EVICT, CL_P1_DDI: src = `L2AMI_SRC_P1;
      default: src = `L2AMI_SRC_P0;
    endcase
  endfunction

  // ************************************************
  // burst legalisation
  // ************************************************
  // shapes outside the processor subset are clamped rather than refused
  always_comb begin
    logic lf;
    lf = req_i.cls inside {CL_P0_DFILL, CL_P0_IFILL, CL_P1_DFILL, CL_P1_IFILL};
    form.write = is_wr;
    form.id = req_i.cls;
    form.addr = req_i.addr;
    form.len = `L2AMI_LEN1;
    form.size = req_i.size;
    form.burst = `L2AMI_INCR;
    form.lock = `L2AMI_LK_NORM;
    form.user = 9'h000;
    unique case (req_i.cls)
      CL_CP_RD, CL_CP_WR: begin
        form.len = req_i.len;
        form.lock = req_i.lock;
        form.burst = (req_i.burst == `L2AMI_FIXED) ? `L2AMI_INCR : req_i.burst;
      end
      CL_P0_DFILL, CL_P0_IFILL, CL_P1_DFILL, CL_P1_IFILL: begin
        form.len = `L2AMI_LEN4;
        form.size = `L2AMI_SZ64;
        form.burst = `L2AMI_WRAP;
      end
      CL_P0_EVICT, CL_P0_DDI, CL_P1_EVICT, CL_P1_DDI: begin
        form.len = `L2AMI_LEN4;
        form.size = `L2AMI_SZ64;
      end
      CL_P0_NCRD, CL_P1_NCRD: begin
        if (req_i.swap) begin
          form.lock = `L2AMI_LK_LOCK;
          form.size = (req_i.size == `L2AMI_SZ8) ? `L2AMI_SZ8 : `L2AMI_SZ32;
        end else if (req_i.excl) begin
          form.lock = `L2AMI_LK_EXCL;
        end else if (req_i.ifetch) begin
          form.len = `L2AMI_LEN4;
          form.size = `L2AMI_SZ64;
          form.burst = `L2AMI_WRAP;
        end else if (req_i.size == `L2AMI_SZ64) begin
          form.len = (req_i.len > `L2AMI_LEN4) ? `L2AMI_LEN4 : req_i.len;
        end else if (req_i.size == `L2AMI_SZ32) begin
          form.len = (req_i.len > `L2AMI_LEN8) ? `L2AMI_LEN8 : req_i.len;
        end
      end
      default: begin
        // processor writes, 32-bit may pair
        if (req_i.swap) begin
          form.lock = `L2AMI_LK_LOCK;
          form.size = (req_i.size == `L2AMI_SZ8) ? `L2AMI_SZ8 : `L2AMI_SZ32;
        end else if (req_i.excl) begin
          form.lock = `L2AMI_LK_EXCL;
        end else if (req_i.size == `L2AMI_SZ32) begin
          form.len = (req_i.len > `L2AMI_LEN2) ? `L2AMI_LEN2 : req_i.len;
        end
      end
    endcase
    if (!is_wr) begin
      form.user[`L2AMI_U_SRC] = src(req_i.cls);
      form.user[`L2AMI_U_SPEC] = req_i.spec & lf;
      form.user[`L2AMI_U_RSV] = 1'b0;
      form.user[`L2AMI_U_ATTR] = req_i.wthru ? `L2AMI_ATTR_WT : req_i.attr;
      form.user[`L2AMI_U_SHR] = req_i.share;
    end
  end

  // ************************************************
  // acceptance
  // ************************************************
  // address filter
  assign tgt = HAS_PORT1 && (req_i.addr >= port1_base_i) && (req_i.addr <= port1_limit_i);
  assign is_wr = (req_i.cls >= CL_CP_WR);
  assign lim_ok = (st_reg.cnt[req_i.cls] < lim(req_i.cls)) && (st_reg.total < `L2AMI_LIM_TOTAL);
  // one write in flight: a new write waits for the last beat of the previous one
  assign req_ready_o = lim_ok && (!st_reg.av[tgt] || addr_ready_i[tgt]) && !(is_wr && st_reg.wbusy);
  assign take = req_valid_i && req_ready_o;
  assign wdat_ready_o = st_reg.wbusy && (!st_reg.wv || w_ready_i[st_reg.wport]) && !(st_reg.wv && st_reg.w.last);
  assign wtake = wdat_valid_i && wdat_ready_o;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    st_next = st_reg;
    for (int p = 0; p < 2; p++) begin
      if (st_reg.av[p] && addr_ready_i[p]) begin
        st_next.av[p] = 1'b0;
      end
    end
    if (take) begin
      st_next.av[tgt] = 1'b1;
      st_next.ach[tgt] = form;
      if (is_wr) begin
        st_next.wbusy = 1'b1;
        st_next.wport = tgt;
      end
    end
    // beats pass one at a time; the last one frees the write path
    if (st_reg.wv && w_ready_i[st_reg.wport]) begin
      st_next.wv = 1'b0;
      if (st_reg.w.last) begin
        st_next.wbusy = 1'b0;
      end
    end
    if (wtake) begin
      st_next.wv = 1'b1;
      st_next.w = wdat_i;
    end
    for (int i = 0; i < 14; i++) begin
      st_next.cnt[i] = st_reg.cnt[i] + 5'(take && (req_i.cls == i))
        - 5'(rd_done_i && (rd_done_cls_i == i)) - 5'(wr_done_i && (wr_done_cls_i == i));
    end
    st_next.total = st_reg.total + 7'(take) - 7'(rd_done_i) - 7'(wr_done_i);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign addr_valid_o = st_reg.av;
  assign addr_o = st_reg.ach;
  assign w_valid_o = {st_reg.wv && st_reg.wport, st_reg.wv && !st_reg.wport};
  assign w_o = st_reg.w;
  assign outstanding_o = st_reg.total;
  assign wr_busy_o = st_reg.wbusy;

  // ************************************************
  // checks
  // ************************************************
  always_comb begin
    rd_sum = '0;
    wr_sum = '0;
    for (int i = 0; i < 7; i++) begin
      rd_sum = rd_sum + 7'(st_reg.cnt[i]);
      wr_sum = wr_sum + 7'(st_reg.cnt[i + 7]);
    end
  end

  property p_total;
    @(posedge clock_i) disable iff (srst_i) st_reg.total <= `L2AMI_LIM_TOTAL;
  endproperty
  a_total: assert property (p_total) else $error("total outstanding over limit");
  property p_rdcap;
    @(posedge clock_i) disable iff (srst_i) rd_sum <= ((NUM_CPU > 1) ? `L2AMI_LIM_RD2 : `L2AMI_LIM_RD1);
  endproperty
  a_rdcap: assert property (p_rdcap) else $error("read issue cap exceeded");
  property p_wrcap;
    @(posedge clock_i) disable iff (srst_i) wr_sum <= ((NUM_CPU > 1) ? `L2AMI_LIM_WR2 : `L2AMI_LIM_WR1);
  endproperty
  a_wrcap: assert property (p_wrcap) else $error("write issue cap exceeded");
  property p_nointlv;
    @(posedge clock_i) disable iff (srst_i) take && is_wr |=> st_reg.wbusy && !req_ready_o || !is_wr;
  endproperty
  a_nointlv: assert property (p_nointlv) else $error("second write taken while data pending");
  property p_wrap;
    @(posedge clock_i) disable iff (srst_i) st_reg.av[0] && st_reg.ach[0].burst == `L2AMI_WRAP
      && !(st_reg.ach[0].id inside {CL_CP_RD, CL_CP_WR}) // coherency traffic may wrap in any shape
      |-> !st_reg.ach[0].write && st_reg.ach[0].len == `L2AMI_LEN4 && st_reg.ach[0].size == `L2AMI_SZ64;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap burst of wrong shape");
  property p_nofixed;
    @(posedge clock_i) disable iff (srst_i) st_reg.av[0] |-> st_reg.ach[0].burst != `L2AMI_FIXED;
  endproperty
  a_nofixed: assert property (p_nofixed) else $error("fixed burst issued");
  property p_user;
    @(posedge clock_i) disable iff (srst_i) st_reg.av[0] && !st_reg.ach[0].write
      |-> !st_reg.ach[0].user[`L2AMI_U_RSV] && st_reg.ach[0].user[`L2AMI_U_SRC] != 2'h3;
  endproperty
  a_user: assert property (p_user) else $error("reserved user code driven");
  property p_wt;
    @(posedge clock_i) disable iff (srst_i) take && !is_wr && req_i.wthru && !tgt
      |=> st_reg.ach[0].user[`L2AMI_U_ATTR] == `L2AMI_ATTR_WT && st_reg.av[0];
  endproperty
  a_wt: assert property (p_wt) else $error("write-through attribute wrong");
  property p_spec;
    @(posedge clock_i) disable iff (srst_i) take && !(req_i.cls inside {CL_P0_DFILL, CL_P0_IFILL,
      CL_P1_DFILL, CL_P1_IFILL}) |-> !form.user[`L2AMI_U_SPEC];
  endproperty
  a_spec: assert property (p_spec) else $error("speculative hint on non-linefill");
  property p_ncwr;
    @(posedge clock_i) disable iff (srst_i) take && req_i.cls inside {CL_P0_NCWR, CL_P1_NCWR}
      && req_i.size == `L2AMI_SZ64 |-> form.len == `L2AMI_LEN1;
  endproperty
  a_ncwr: assert property (p_ncwr) else $error("64-bit nc write not single");
  property p_port1;
    @(posedge clock_i) disable iff (srst_i) st_reg.av[1]
      |-> HAS_PORT1 && st_reg.ach[1].addr >= port1_base_i && st_reg.ach[1].addr <= port1_limit_i;
  endproperty
  a_port1: assert property (p_port1) else $error("absent port used");
  property p_cov_fill;
    @(posedge clock_i) disable iff (srst_i) take && req_i.cls == CL_P0_DFILL;
  endproperty
  c_fill: cover property (p_cov_fill);
  property p_cov_stall;
    @(posedge clock_i) disable iff (srst_i) req_valid_i && !lim_ok;
  endproperty
  c_stall: cover property (p_cov_stall);
  property p_cov_wr;
    @(posedge clock_i) disable iff (srst_i) take && is_wr ##[1:20] st_reg.wv && st_reg.w.last;
  endproperty
  c_wr: cover property (p_cov_wr);
endmodule

// *** design/l2ami_defs.svh ***
// Purpose: constants of the level-two master interface
// Assumes: included by its bare name
// Notes: widths follow the address and user channels
`ifndef L2AMI_DEFS_SVH
`define L2AMI_DEFS_SVH
// issue limits per traffic class, in total and per direction
`define L2AMI_LIM_CP 5'h0F
`define L2AMI_LIM_DFILL 5'h04
`define L2AMI_LIM_IFILL 5'h08
`define L2AMI_LIM_NCRD 5'h04
`define L2AMI_LIM_NCWR 5'h08
`define L2AMI_LIM_EVICT 5'h04
`define L2AMI_LIM_DDI 5'h02
`define L2AMI_LIM_TOTAL 7'h58
`define L2AMI_LIM_WR1 7'h1D
`define L2AMI_LIM_WR2 7'h29
`define L2AMI_LIM_RD1 7'h1F
`define L2AMI_LIM_RD2 7'h2F
// burst, size and lock codes
`define L2AMI_FIXED 2'h0
`define L2AMI_INCR 2'h1
`define L2AMI_WRAP 2'h2
`define L2AMI_SZ8 3'h0
`define L2AMI_SZ32 3'h2
`define L2AMI_SZ64 3'h3
`define L2AMI_LEN1 4'h0
`define L2AMI_LEN2 4'h1
`define L2AMI_LEN4 4'h3
`define L2AMI_LEN8 4'h7
`define L2AMI_LK_NORM 2'h0
`define L2AMI_LK_EXCL 2'h1
`define L2AMI_LK_LOCK 2'h2
// read user field layout and source codes
`define L2AMI_U_SRC 8:7
`define L2AMI_U_SPEC 6
`define L2AMI_U_RSV 5
`define L2AMI_U_ATTR 4:1
`define L2AMI_U_SHR 0
`define L2AMI_SRC_P0 2'h0
`define L2AMI_SRC_P1 2'h2
`define L2AMI_SRC_CP 2'h1
`define L2AMI_ATTR_WT 4'h6
`endif

// *** design/l2ami_pkg.sv ***
// Purpose: types of the level-two master interface
// Assumes: constants come from l2ami_defs.svh
// Notes: class code doubles as the transaction id
package l2ami_pkg;
  // traffic classes, reads 0..6 and writes 7..13
  typedef enum logic [3:0] {
    CL_CP_RD = 4'h0, CL_P0_DFILL = 4'h1, CL_P0_IFILL = 4'h2, CL_P0_NCRD = 4'h3,
    CL_P1_DFILL = 4'h4, CL_P1_IFILL = 4'h5, CL_P1_NCRD = 4'h6,
    CL_CP_WR = 4'h7, CL_P0_NCWR = 4'h8, CL_P0_EVICT = 4'h9, CL_P0_DDI = 4'hA,
    CL_P1_NCWR = 4'hB, CL_P1_EVICT = 4'hC, CL_P1_DDI = 4'hD
  } l2ami_cls_t;
  // request from the processor side or coherency_slave_port
  typedef struct packed {
    l2ami_cls_t cls;
    logic [31:0] addr;
    logic [3:0] len;
    logic [2:0] size;
    logic [1:0] burst;
    logic [1:0] lock;
    logic excl;
    logic swap;
    logic ifetch;
    logic wthru;
    logic [3:0] attr;
    logic share;
    logic spec;
  } l2ami_req_t;
  // address channel of one master port
  typedef struct packed {
    logic write;
    l2ami_cls_t id;
    logic [31:0] addr;
    logic [3:0] len;
    logic [2:0] size;
    logic [1:0] burst;
    logic [1:0] lock;
    logic [8:0] user;
  } l2ami_ach_t;
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] strb;
    logic last;
  } l2ami_wdat_t;
  // whole module state
  typedef struct packed {
    logic [13:0][4:0] cnt;
    logic [6:0] total;
    logic [1:0] av;
    l2ami_ach_t [1:0] ach;
    logic wbusy;
    logic wport;
    logic wv;
    l2ami_wdat_t w;
  } l2ami_st_t;
endpackage

// *** tb/l2ami_slave_model.sv ***
// Purpose: far-side slave model of both level-two master ports
// Assumes: only one write carries data at a time
// Notes: completions come back in issue order; slow mode thins ready and completions
module l2ami_slave_model (
  // clock, reset and pacing
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic slow_i,
  input wire logic hold_i,
  // address and write data channels
  input wire logic [1:0] addr_valid_i,
  input wire l2ami_pkg::l2ami_ach_t [1:0] addr_i,
  output logic [1:0] addr_ready_o,
  input wire logic [1:0] w_valid_i,
  input wire l2ami_pkg::l2ami_wdat_t w_i,
  output logic [1:0] w_ready_o,
  // completions
  output logic rd_done_o,
  output l2ami_pkg::l2ami_cls_t rd_done_cls_o,
  output logic wr_done_o,
  output l2ami_pkg::l2ami_cls_t wr_done_cls_o
);
  import l2ami_pkg::*;
  // ****************
  // slave behaviour
  // ****************
  logic [7:0] cnt_reg;
  l2ami_cls_t rq[$];
  l2ami_cls_t wq[$];
  l2ami_cls_t wd[$];
  int wl = 0;
  // idle id lines carry a moving pattern so a stale id is never mistaken for a live one
  always @(posedge clock_i) begin
    cnt_reg <= srst_i ? 8'h00 : cnt_reg + 8'h01;
    rd_done_o <= 1'b0;
    wr_done_o <= 1'b0;
    rd_done_cls_o <= l2ami_cls_t'(cnt_reg[3:0]);
    wr_done_cls_o <= l2ami_cls_t'(~cnt_reg[3:0]);
    if (srst_i) begin
      rq.delete();
      wq.delete();
      wd.delete();
      wl = 0;
      addr_ready_o <= 2'b00;
      w_ready_o <= 2'b00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (addr_valid_i[p] && addr_ready_o[p]) begin
          if (addr_i[p].write) wq.push_back(addr_i[p].id);
          else rq.push_back(addr_i[p].id);
        end
        if (w_valid_i[p] && w_ready_o[p] && w_i.last) wl++;
      end
      // a last beat may overtake its own address on a slow address channel, so pair them by count
      if (wl > 0 && wq.size() > 0) begin
        wd.push_back(wq.pop_front());
        wl--;
      end
      addr_ready_o <= (slow_i && cnt_reg[1:0] != 2'h0) ? 2'b00 : 2'b11;
      w_ready_o <= (slow_i && cnt_reg[0]) ? 2'b00 : 2'b11;
      // a write completes only after its last beat, never before its address
      if (!hold_i && (!slow_i || cnt_reg[2])) begin
        if (rq.size() > 0) begin
          rd_done_o <= 1'b1;
          rd_done_cls_o <= rq.pop_front();
        end
        if (wd.size() > 0) begin
          wr_done_o <= 1'b1;
          wr_done_cls_o <= wd.pop_front();
        end
      end
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the level-two master interface
// Assumes: the slave model answers every issued transaction
// Notes: expected address and data beats queue up and are compared as the handshake happens
`include "l2ami_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import l2ami_pkg::*;
  // ****************
  // bench
  // ****************
  logic clock_i, srst_i, req_valid_i, wdat_valid_i, slow, hold;
  logic req_ready_o, wdat_ready_o, rd_done_i, wr_done_i, wr_busy_o;
  logic [1:0] addr_valid_o, addr_ready_i, w_valid_o, w_ready_i;
  logic [6:0] outstanding_o;
  logic [31:0] seed = 32'h00000034;
  l2ami_req_t req_i, r;
  l2ami_wdat_t wdat_i, w_o;
  l2ami_ach_t [1:0] addr_o;
  l2ami_cls_t rd_done_cls_i, wr_done_cls_i;
  l2ami_ach_t exq[2][$];
  l2ami_wdat_t wq[$];
  int errors = 0;
  int num_checks = 0;
  l2ami_top #(.NUM_CPU(2), .HAS_PORT1(1'b1)) i_dut (.clock_i(clock_i), .srst_i(srst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .wdat_valid_i(wdat_valid_i),
    .wdat_i(wdat_i), .wdat_ready_o(wdat_ready_o), .port1_base_i(32'h80000000), .port1_limit_i(32'h8FFFFFFF),
    .addr_valid_o(addr_valid_o), .addr_o(addr_o), .addr_ready_i(addr_ready_i), .w_valid_o(w_valid_o),
    .w_o(w_o), .w_ready_i(w_ready_i), .rd_done_i(rd_done_i), .rd_done_cls_i(rd_done_cls_i),
    .wr_done_i(wr_done_i), .wr_done_cls_i(wr_done_cls_i), .outstanding_o(outstanding_o), .wr_busy_o(wr_busy_o));
  l2ami_slave_model i_slave (.clock_i(clock_i), .srst_i(srst_i), .slow_i(slow), .hold_i(hold),
    .addr_valid_i(addr_valid_o), .addr_i(addr_o), .addr_ready_o(addr_ready_i), .w_valid_i(w_valid_o),
    .w_i(w_o), .w_ready_o(w_ready_i), .rd_done_o(rd_done_i), .rd_done_cls_o(rd_done_cls_i),
    .wr_done_o(wr_done_i), .wr_done_cls_o(wr_done_cls_i));
  // free-running 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // request at a random low address, outside the port one window
  function automatic l2ami_req_t mk(l2ami_cls_t c, logic [3:0] ln, logic [2:0] sz, logic [1:0] b, logic [3:0] at);
    logic [31:0] a;
    a = rnd();
    return '{cls: c, addr: {4'h0, a[27:3], 3'h0}, len: ln, size: sz, burst: b, attr: at, default: '0};
  endfunction
  // expected address beat; user carries source, hint, zero, attribute and share on reads
  function automatic l2ami_ach_t ex(l2ami_req_t q, logic [3:0] ln, logic [2:0] sz, logic [1:0] b, logic [1:0] lk,
                                    logic sp, logic [3:0] at);
    logic w;
    logic [1:0] s;
    w = q.cls >= CL_CP_WR;
    s = (q.cls inside {CL_CP_RD, CL_CP_WR}) ? `L2AMI_SRC_CP :
        (q.cls inside {CL_P1_DFILL, CL_P1_IFILL, CL_P1_NCRD}) ? `L2AMI_SRC_P1 : `L2AMI_SRC_P0;
    return {w, q.cls, q.addr, ln, sz, b, lk, w ? 9'h000 : {s, sp, 1'b0, at, q.share}};
  endfunction
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic hang();
    errors++;
    $display("unexpected handshake: expected within bound, seen none");
    test_done();
  endtask
  task automatic send(l2ami_req_t q, int p, l2ami_ach_t e);
    exq[p].push_back(e);
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_i <= q;
    for (int i = 0; i <= 200; i++) begin
      @(negedge clock_i);
      if (req_ready_o === 1'b1) break;
      if (i == 200) hang();
    end
    @(posedge clock_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic beat(logic [7:0] st, logic lst);
    l2ami_wdat_t d;
    d = {rnd(), rnd(), st, lst};
    wq.push_back(d);
    @(posedge clock_i);
    wdat_valid_i <= 1'b1;
    wdat_i <= d;
    for (int i = 0; i <= 200; i++) begin
      @(negedge clock_i);
      if (wdat_ready_o === 1'b1) break;
      if (i == 200) hang();
    end
    @(posedge clock_i);
    wdat_valid_i <= 1'b0;
  endtask
  // a refused request is offered for one cycle only, then withdrawn
  task automatic refuse(l2ami_req_t q);
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_i <= q;
    @(negedge clock_i);
    chk("req_ready_o", 64'h0, 64'(req_ready_o));
    @(posedge clock_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic fin(string n);
    for (int i = 0; i <= 500; i++) begin
      @(negedge clock_i);
      if (exq[0].size() + exq[1].size() + wq.size() == 0 && outstanding_o === 7'h00 && wr_busy_o === 1'b0) break;
      if (i == 500) hang();
    end
    $display("test %0s done", n);
  endtask
  // handshakes seen at the negedge before the edge that takes them; port one user is not compared
  always @(negedge clock_i) begin
    l2ami_ach_t e;
    l2ami_wdat_t d;
    for (int p = 0; p < 2; p++) begin
      if (addr_valid_o[p] === 1'b1 && addr_ready_i[p] === 1'b1) begin
        e = (exq[p].size() > 0) ? exq[p].pop_front() : '1;
        chk("addr_o", 64'(e & (p ? ~57'h1FF : '1)), 64'(addr_o[p] & (p ? ~57'h1FF : '1)));
      end
    end
    if (|(w_valid_o & w_ready_i) === 1'b1) begin
      d = (wq.size() > 0) ? wq.pop_front() : '1;
      chk("w_o", 64'(d.data), 64'(w_o.data));
      chk("w_o strobes", 64'({d.strb, d.last}), 64'({w_o.strb, w_o.last}));
    end
  end
  initial begin
    srst_i = 1'b1;
    req_valid_i = 1'b0;
    wdat_valid_i = 1'b0;
    req_i = '0;
    wdat_i = '0;
    slow = 1'b0;
    hold = 1'b0;
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    // processor and coherency read shapes and the read user field
    r = mk(CL_P0_DFILL, 4'h0, `L2AMI_SZ32, `L2AMI_INCR, 4'hF);
    r.spec = 1'b1;
    r.share = 1'b1;
    send(r, 0, ex(r, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_WRAP, `L2AMI_LK_NORM, 1'b1, 4'hF));
    r = mk(CL_P0_IFILL, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_WRAP, 4'h7);
    send(r, 0, ex(r, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_WRAP, `L2AMI_LK_NORM, 1'b0, 4'h7));
    r = mk(CL_P0_NCRD, 4'h0, `L2AMI_SZ64, `L2AMI_INCR, 4'h3);
    r.ifetch = 1'b1;
    r.spec = 1'b1;
    send(r, 0, ex(r, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_WRAP, `L2AMI_LK_NORM, 1'b0, 4'h3));
    r = mk(CL_P0_NCRD, `L2AMI_LEN8, `L2AMI_SZ32, `L2AMI_INCR, 4'h1);
    send(r, 0, ex(r, `L2AMI_LEN8, `L2AMI_SZ32, `L2AMI_INCR, `L2AMI_LK_NORM, 1'b0, 4'h1));
    r = mk(CL_P0_NCRD, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_INCR, 4'h0);
    send(r, 0, ex(r, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_INCR, `L2AMI_LK_NORM, 1'b0, 4'h0));
    r = mk(CL_P0_NCRD, `L2AMI_LEN4, `L2AMI_SZ8, `L2AMI_INCR, 4'h3);
    send(r, 0, ex(r, `L2AMI_LEN1, `L2AMI_SZ8, `L2AMI_INCR, `L2AMI_LK_NORM, 1'b0, 4'h3));
    r = mk(CL_P0_NCRD, `L2AMI_LEN1, `L2AMI_SZ64, `L2AMI_INCR, 4'h3);
    r.wthru = 1'b1;
    send(r, 0, ex(r, `L2AMI_LEN1, `L2AMI_SZ64, `L2AMI_INCR, `L2AMI_LK_NORM, 1'b0, `L2AMI_ATTR_WT));
    r = mk(CL_P0_NCRD, `L2AMI_LEN1, 3'h1, `L2AMI_INCR, 4'h1);
    r.swap = 1'b1;
    send(r, 0, ex(r, `L2AMI_LEN1, `L2AMI_SZ32, `L2AMI_INCR, `L2AMI_LK_LOCK, 1'b0, 4'h1));
    r = mk(CL_P0_NCRD, `L2AMI_LEN4, `L2AMI_SZ8, `L2AMI_INCR, 4'h3);
    r.excl = 1'b1;
    send(r, 0, ex(r, `L2AMI_LEN1, `L2AMI_SZ8, `L2AMI_INCR, `L2AMI_LK_EXCL, 1'b0, 4'h3));
    r = mk(CL_CP_RD, 4'h5, 3'h1, `L2AMI_FIXED, 4'hF);
    send(r, 0, ex(r, 4'h5, 3'h1, `L2AMI_INCR, `L2AMI_LK_NORM, 1'b0, 4'hF));
    r = mk(CL_P1_DFILL, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_WRAP, 4'hF);
    r.addr = 32'h80000100;
    send(r, 1, ex(r, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_WRAP, `L2AMI_LK_NORM, 1'b0, 4'hF));
    fin("read shapes");
    // eviction data; a second write waits for the last beat, slave slow
    slow <= 1'b1;
    r = mk(CL_P0_EVICT, 4'h0, `L2AMI_SZ64, `L2AMI_INCR, 4'hF);
    send(r, 0, ex(r, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_INCR, `L2AMI_LK_NORM, 1'b0, 4'hF));
    r = mk(CL_P0_NCWR, `L2AMI_LEN2, `L2AMI_SZ64, `L2AMI_INCR, 4'h3);
    refuse(r);
    for (int k = 0; k < 4; k++) beat((k == 2) ? 8'h00 : 8'(rnd()), k == 3);
    send(r, 0, ex(r, `L2AMI_LEN1, `L2AMI_SZ64, `L2AMI_INCR, `L2AMI_LK_NORM, 1'b0, 4'h3));
    beat(8'hFF, 1'b1);
    r = mk(CL_P0_NCWR, `L2AMI_LEN4, `L2AMI_SZ32, `L2AMI_INCR, 4'h3);
    send(r, 0, ex(r, `L2AMI_LEN2, `L2AMI_SZ32, `L2AMI_INCR, `L2AMI_LK_NORM, 1'b0, 4'h3));
    beat(8'h0F, 1'b0);
    beat(8'hF0, 1'b1);
    fin("writes");
    // four data linefills held open, the fifth must wait
    slow <= 1'b0;
    hold <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      r = mk(CL_P0_DFILL, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_WRAP, 4'h7);
      send(r, 0, ex(r, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_WRAP, `L2AMI_LK_NORM, 1'b0, 4'h7));
    end
    refuse(r);
    @(negedge clock_i);
    chk("outstanding_o", 64'h4, 64'(outstanding_o));
    hold <= 1'b0;
    send(r, 0, ex(r, `L2AMI_LEN4, `L2AMI_SZ64, `L2AMI_WRAP, `L2AMI_LK_NORM, 1'b0, 4'h7));
    fin("linefill limit");
    test_done();
  end
endmodule
